// [inc/eis_pkg.sv]
package eis_pkg;

	// register byte offsets on the plain register port
	localparam logic [7:0]  ENABLE_OFS        = 8'h90;
	localparam logic [7:0]  PENDING_OFS       = 8'h92;
	localparam logic [7:0]  WAKE_CLEAR_OFS    = 8'hd4;
	localparam logic [7:0]  RAW_EVENT_OFS     = 8'hd6;

	localparam int unsigned ADDR_W            = 8;
	localparam int unsigned DATA_W            = 16;

	// bit positions shared by enable and pending registers
	localparam int unsigned LINK_CHANGE_BIT   = 15;
	localparam int unsigned TX_DONE_BIT       = 14;
	localparam int unsigned RX_FRAME_BIT      = 13;
	localparam int unsigned RX_OVERRUN_BIT    = 11;
	localparam int unsigned TX_STOPPED_BIT    = 9;
	localparam int unsigned RX_STOPPED_BIT    = 8;
	localparam int unsigned TX_SPACE_BIT      = 6;
	localparam int unsigned WAKE_FRAME_BIT    = 5;
	localparam int unsigned MAGIC_FRAME_BIT   = 4;
	localparam int unsigned LINKUP_WAKE_BIT   = 3;
	localparam int unsigned ENERGY_WAKE_BIT   = 2;
	localparam int unsigned RESERVED_EN_BIT   = 1;
	localparam int unsigned DELAYED_WAKE_BIT  = 0;

	// wake clear field of the power event control register
	localparam int unsigned WAKE_CLEAR_LSB    = 2;
	localparam int unsigned WAKE_CLEAR_MSB    = 5;
	localparam logic [3:0]  WAKE_CLR_FRAME    = 4'h8;
	localparam logic [3:0]  WAKE_CLR_MAGIC    = 4'h4;
	localparam logic [3:0]  WAKE_CLR_LINKUP   = 4'h2;
	localparam logic [3:0]  WAKE_CLR_ENERGY   = 4'h1;

	// reset values and masks
	localparam logic [15:0] ENABLE_RST        = 16'h0000;
	localparam logic [15:0] PENDING_RST       = 16'h0300;
	localparam logic [15:0] ENABLE_WMASK      = 16'hfffd;
	localparam logic [15:0] W1C_MASK          = 16'heb40;
	localparam logic [15:0] WAKE_MASK         = 16'h003c;
	localparam logic [15:0] IRQ_SRC_MASK      = 16'heb7c;

	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} eis_bus_req_t;

	typedef struct packed {
		logic link_change;
		logic transmit_done;
		logic frame_received;
		logic receive_overrun;
		logic tx_process_stopped;
		logic rx_process_stopped;
		logic tx_space_available;
		logic wake_frame;
		logic magic_frame;
		logic linkup_wake;
		logic energy_wake;
		logic delayed_energy_wake;
	} eis_events_t;

	typedef struct packed {
		logic [DATA_W-1:0] enable;
		logic [DATA_W-1:0] pending;
		logic [DATA_W-1:0] event_prev;
		logic              delayed_held;
		logic [DATA_W-1:0] rdata;
		logic              irq;
	} eis_state_t;

endpackage : eis_pkg

// [verilog/eis_irq_ctrl.sv]
`timescale 1ns/1ns

module eis_irq_ctrl
(
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	input  wire eis_pkg::eis_bus_req_t bus_req,
	output logic [eis_pkg::DATA_W-1:0] bus_rdata,
	input  wire eis_pkg::eis_events_t  events,
	input  wire logic                 host_ready,
	output logic                      host_irq_n
);

	eis_pkg::eis_state_t state_reg;
	eis_pkg::eis_state_t state_next;

	logic [eis_pkg::DATA_W-1:0] event_raw;
	logic [eis_pkg::DATA_W-1:0] event_rise;

	// address match, shared by write and read decoding
	function automatic logic eis_hit
	(
		input logic [eis_pkg::ADDR_W-1:0] addr,
		input logic [eis_pkg::ADDR_W-1:0] ofs
	);
		eis_hit = (addr == ofs);
	endfunction : eis_hit

	// places each event source at its enable bit position
	function automatic logic [eis_pkg::DATA_W-1:0] eis_event_vector
	(
		input eis_pkg::eis_events_t ev
	);
		logic [eis_pkg::DATA_W-1:0] v;
		v = 16'h0000;
		v[eis_pkg::LINK_CHANGE_BIT]  = ev.link_change;
		v[eis_pkg::TX_DONE_BIT]      = ev.transmit_done;
		v[eis_pkg::RX_FRAME_BIT]     = ev.frame_received;
		v[eis_pkg::RX_OVERRUN_BIT]   = ev.receive_overrun;
		v[eis_pkg::TX_STOPPED_BIT]   = ev.tx_process_stopped;
		v[eis_pkg::RX_STOPPED_BIT]   = ev.rx_process_stopped;
		v[eis_pkg::TX_SPACE_BIT]     = ev.tx_space_available;
		v[eis_pkg::WAKE_FRAME_BIT]   = ev.wake_frame;
		v[eis_pkg::MAGIC_FRAME_BIT]  = ev.magic_frame;
		v[eis_pkg::LINKUP_WAKE_BIT]  = ev.linkup_wake;
		v[eis_pkg::ENERGY_WAKE_BIT]  = ev.energy_wake;
		v[eis_pkg::DELAYED_WAKE_BIT] = ev.delayed_energy_wake;
		eis_event_vector = v;
	endfunction : eis_event_vector

	// one-hot wake clear code to the pending bits it clears
	function automatic logic [eis_pkg::DATA_W-1:0] eis_wake_clear
	(
		input logic [3:0] code
	);
		logic [eis_pkg::DATA_W-1:0] c;
		c = 16'h0000;
		case (code)
			eis_pkg::WAKE_CLR_FRAME:
			begin
				c[eis_pkg::WAKE_FRAME_BIT] = 1'b1;
			end
			eis_pkg::WAKE_CLR_MAGIC:
			begin
				c[eis_pkg::MAGIC_FRAME_BIT] = 1'b1;
			end
			eis_pkg::WAKE_CLR_LINKUP:
			begin
				c[eis_pkg::LINKUP_WAKE_BIT] = 1'b1;
			end
			eis_pkg::WAKE_CLR_ENERGY:
			begin
				c[eis_pkg::ENERGY_WAKE_BIT] = 1'b1;
			end
			// any code that is not one-hot clears nothing
			default:
			begin
				c = 16'h0000;
			end
		endcase
		eis_wake_clear = c;
	endfunction : eis_wake_clear

	assign event_raw = eis_event_vector(events);

	// event sources are same-clock levels; only a rising edge sets a bit
	genvar gi;
	generate
		for (gi = 0; gi < eis_pkg::DATA_W; gi++)
		begin : g_edge
			assign event_rise[gi] = event_raw[gi] & ~state_reg.event_prev[gi];
		end
	endgenerate

	always_comb
	begin
		logic [eis_pkg::DATA_W-1:0] set_bits;
		logic [eis_pkg::DATA_W-1:0] clr_bits;
		logic                       wr_enable;
		logic                       wr_pending;
		logic                       wr_wake;
		logic                       delayed_rise;
		logic                       delayed_release;

		set_bits        = 16'h0000;
		clr_bits        = 16'h0000;
		wr_enable       = 1'b0;
		wr_pending      = 1'b0;
		wr_wake         = 1'b0;
		delayed_rise    = 1'b0;
		delayed_release = 1'b0;

		state_next            = state_reg;
		state_next.event_prev = event_raw;

		wr_enable  = bus_req.wr & eis_hit(bus_req.addr, eis_pkg::ENABLE_OFS);
		wr_pending = bus_req.wr & eis_hit(bus_req.addr, eis_pkg::PENDING_OFS);
		wr_wake    = bus_req.wr & eis_hit(bus_req.addr, eis_pkg::WAKE_CLEAR_OFS);

		// reserved positions 12, 10, 7 are kept; bit 1 is never written
		if (wr_enable)
		begin
			state_next.enable = bus_req.wdata & eis_pkg::ENABLE_WMASK;
		end

		// plain edge events land on their own positions
		set_bits = event_rise & eis_pkg::IRQ_SRC_MASK;

		// energy edge counts as immediate only while the delayed mode is off
		if (state_reg.enable[eis_pkg::DELAYED_WAKE_BIT])
		begin
			set_bits[eis_pkg::ENERGY_WAKE_BIT] = 1'b0;
		end

		// delayed energy event waits until the host side can take accesses
		delayed_rise = event_rise[eis_pkg::DELAYED_WAKE_BIT] & state_reg.enable[eis_pkg::DELAYED_WAKE_BIT];
		if (delayed_rise)
		begin
			state_next.delayed_held = 1'b1;
		end
		delayed_release = (state_reg.delayed_held | delayed_rise) & host_ready;
		if (delayed_release)
		begin
			set_bits[eis_pkg::ENERGY_WAKE_BIT] = 1'b1;
			state_next.delayed_held            = 1'b0;
		end

		// write-one-to-clear on the non-wake bits 15, 14, 13, 11, 9, 8, 6 only; zeros leave bits alone
		if (wr_pending)
		begin
			clr_bits = bus_req.wdata & eis_pkg::W1C_MASK;
		end

		// wake bits ignore the pending register and clear from the control write
		if (wr_wake)
		begin
			clr_bits = clr_bits | eis_wake_clear(bus_req.wdata[eis_pkg::WAKE_CLEAR_MSB:eis_pkg::WAKE_CLEAR_LSB]);
		end

		// a set in the same cycle as its clear wins, so no event is lost
		state_next.pending = ((state_reg.pending & ~clr_bits) | set_bits) & eis_pkg::IRQ_SRC_MASK;

		// irq from next state so the pin moves in the same cycle as the flags
		state_next.irq = |(state_next.pending & state_next.enable & eis_pkg::IRQ_SRC_MASK);

		// reads return the value held before this cycle's write; nothing clears
		state_next.rdata = 16'h0000;
		if (bus_req.rd)
		begin
			if (eis_hit(bus_req.addr, eis_pkg::ENABLE_OFS))
			begin
				state_next.rdata = state_reg.enable;
			end
			else if (eis_hit(bus_req.addr, eis_pkg::PENDING_OFS))
			begin
				state_next.rdata = state_reg.pending;
			end
			else if (eis_hit(bus_req.addr, eis_pkg::RAW_EVENT_OFS))
			begin
				state_next.rdata                                = state_reg.event_prev;
				state_next.rdata[eis_pkg::RESERVED_EN_BIT]      = state_reg.delayed_held;
			end
			else
			begin
				state_next.rdata = 16'h0000;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_reg.enable       <= eis_pkg::ENABLE_RST;
			state_reg.pending      <= eis_pkg::PENDING_RST;
			state_reg.event_prev   <= 16'h0000;
			state_reg.delayed_held <= 1'b0;
			state_reg.rdata        <= 16'h0000;
			state_reg.irq          <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign bus_rdata  = state_reg.rdata;
	// pin is active low, as a host interrupt line usually is
	assign host_irq_n = ~state_reg.irq;

endmodule : eis_irq_ctrl

// [verification/eis_irq_ctrl_chk.sv]
`timescale 1ns/1ns
module eis_irq_ctrl_chk
(
	input wire logic                  core_clk,
	input wire logic                  reset,
	input wire eis_pkg::eis_bus_req_t bus_req,
	input wire logic [15:0]           bus_rdata,
	input wire eis_pkg::eis_events_t  events,
	input wire logic                  host_ready,
	input wire logic                  host_irq_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	wire r90 = bus_req.rd && bus_req.addr == 8'h90;
	wire r92 = bus_req.rd && bus_req.addr == 8'h92;
	sequence s_wr_en;
		bus_req.wr && bus_req.addr == 8'h90;
	endsequence
	sequence s_quiet;
		!bus_req.wr;
	endsequence
	a_rdata_idle_zero: assert property (!$past(bus_req.rd) |-> bus_rdata == 16'h0000)
		else $error("read data not zero outside read slot");
	a_irq_after_reset: assert property (disable iff (1'b0) reset |=> host_irq_n)
		else $error("irq pin active after reset");
	a_enable_readback: assert property (s_wr_en ##1 s_quiet ##1 r90 |=> bus_rdata == ($past(bus_req.wdata, 3) & 16'hfffd))
		else $error("enable register readback differs");
	a_mask_off_quiet: assert property (s_wr_en and bus_req.wdata == 16'h0000 |=> host_irq_n)
		else $error("irq pin active with all enables off");
	a_pend_reserved_zero: assert property (r92 |=> (bus_rdata & 16'h1483) == 16'h0000)
		else $error("reserved pending bit reads one");
	a_en_bit1_zero: assert property (r90 |=> !bus_rdata[1])
		else $error("enable bit 1 reads one");
	a_unmapped_read_zero: assert property (bus_req.rd && !(bus_req.addr inside {8'h90, 8'h92, 8'hd6})
		|=> bus_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_read_keeps_bits: assert property (r92 ##1 s_quiet ##1 r92
		|=> (bus_rdata & $past(bus_rdata, 2)) == $past(bus_rdata, 2))
		else $error("pending bit lost by a read");
endmodule : eis_irq_ctrl_chk

bind eis_irq_ctrl eis_irq_ctrl_chk chk_i (.core_clk(core_clk), .reset(reset), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .events(events), .host_ready(host_ready), .host_irq_n(host_irq_n));

// [verification/eis_host_model.sv]
`timescale 1ns/1ns
module eis_host_model
(
	input wire logic   core_clk,
	input wire logic   reset,
	input wire logic   host_irq_n,
	output logic [7:0] svc_count
);
	logic prev_reg;
	// one handler entry per falling edge; a level pin held low is not re-entered
	always_ff @(posedge core_clk)
	begin
		prev_reg <= host_irq_n;
		if (reset)
			svc_count <= 8'h00;
		else if (prev_reg === 1'b1 && host_irq_n === 1'b0)
			svc_count <= svc_count + 8'h01;
	end
endmodule : eis_host_model

// [verification/eis_irq_ctrl_tb.sv]
`timescale 1ns/1ns
module eis_irq_ctrl_tb;
	logic                  core_clk = 0;
	logic                  reset = 1;
	logic                  host_ready = 1;
	eis_pkg::eis_bus_req_t bus_req = '0;
	eis_pkg::eis_events_t  ev = '0;
	logic [15:0]           bus_rdata;
	logic                  host_irq_n;
	logic [7:0]            svc_count;
	int                    n_mismatch = 0;
	int                    num_checks = 0;
	int                    cyc = 0;
	int                    en_m;
	int                    pd_m = 'h300;
	int                    p;
	int                    pos[12] = '{2, 2, 3, 4, 5, 6, 8, 9, 11, 13, 14, 15};
	always #2 core_clk = ~core_clk;
	eis_irq_ctrl uut (.core_clk(core_clk), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.events(ev), .host_ready(host_ready), .host_irq_n(host_irq_n));
	eis_host_model host (.core_clk(core_clk), .reset(reset), .host_irq_n(host_irq_n), .svc_count(svc_count));
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input int d);
		@(posedge core_clk);
		bus_req <= '{rd: !w, wr: w, addr: a, wdata: d[15:0]};
		@(posedge core_clk);
		bus_req <= '0;
	endtask : bus
	task automatic rd(input logic [7:0] a, input int e);
		bus(0, a, 0);
		#1 chk("rdata", bus_rdata, e[15:0]);
	endtask : rd
	task automatic pulse(input int k);
		@(posedge core_clk);
		ev <= 12'(1 << k);
		@(posedge core_clk);
		ev <= '0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : pulse
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			results();
		end
	end
	initial
	begin
		void'($urandom(16));
		repeat (2) @(posedge core_clk);
		reset <= 0;
		rd(8'h90, 0);
		rd(8'h92, pd_m);
		chk("irq_n", 16'(host_irq_n), 16'h1);
		for (int k = 1; k < 12; k++)
		begin
			p = pos[k];
			en_m = 1 << p;
			bus(1, 8'h90, en_m);
			pulse(k);
			pd_m |= en_m;
			rd(8'h92, pd_m);
			chk("irq_n", 16'(host_irq_n), 16'h0);
			bus(1, (p > 1 && p < 6) ? 8'hd4 : 8'h92, en_m);
			pd_m &= ~en_m;
			rd(8'h92, pd_m);
			rd(8'h92, pd_m);
			chk("irq_n", 16'(host_irq_n), 16'h1);
			bus(1, 8'h90, 0);
			pulse(k);
			pd_m |= en_m;
			chk("irq_n", 16'(host_irq_n), 16'h1);
		end
		// delayed source must wait for host_ready even when enabled
		bus(1, 8'hd4, 4);
		pd_m &= ~4;
		bus(1, 8'h90, 'h5);
		host_ready <= 0;
		pulse(0);
		rd(8'h92, pd_m);
		host_ready <= 1;
		repeat (3) @(posedge core_clk);
		pd_m |= 4;
		rd(8'h92, pd_m);
		chk("irq_n", 16'(host_irq_n), 16'h0);
		chk("svc", 16'(svc_count), 16'd12);
		repeat (4)
		begin
			en_m = $urandom;
			bus(1, 8'h90, en_m);
			rd(8'h90, en_m & 'hfffd);
		end
		rd(8'ha0, 0);
		// a second reset in mid-run must bring back the power-on values
		@(posedge core_clk);
		reset <= 1;
		repeat (2) @(posedge core_clk);
		reset <= 0;
		rd(8'h90, 0);
		rd(8'h92, 'h300);
		chk("irq_n", 16'(host_irq_n), 16'h1);
		results();
	end
endmodule : eis_irq_ctrl_tb
